// ===== verilog/switch_matrix_bit_control.sv
/*
  AXI4-Lite slave holding the drive-node and negative-node switch control registers;
  each writable bit drives one analog switch enable output, 1 closes the switch.
  assumes a single clock, synchronous active-low reset, and at most one write and one read in flight.
*/
// Register access over AXI4-Lite is this design's own decision.
// How it works
// - drive-node register at 0x2150, resets to zero, all drive switches open
// - drive bit 7 read/write, closes drive node to auxiliary pin three switch
// - drive bit 6 read/write, closes drive node to sense electrode switch
// - drive bit 4 read/write, closes data-out to counter electrode switch
// - drive bits 3,2,1 read/write, close data-out to inputs three, two, one
// - drive bit 0 read/write, closes data-out to calibration resistor zero
// - negative-node register at 0x2154, resets to zero, all switches open
// - negative bit 11 read/write, closes secondary low-side switch
// - negative bit 10 read/write, shorts negative node to TIA inverting input
// - negative bit 9 read/write, closes negative node to calibration resistor one
// - negative bit 8 read/write, closes direct sense switch bypassing load resistor
// - negative bits 6..0 read/write individual switches; bit 7 reserved
`timescale 1ns/1ns
`include "switch_matrix_regs.svh"

module switch_matrix_bit_control #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic resetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic drive_to_aux_pin_switch, // closes drive node to auxiliary pin three
  output logic drive_to_sense_pin_switch, // closes drive node to sense electrode pin
  output logic dataout_to_counter_pin_switch, // closes data-out to counter electrode pin
  output logic dataout_to_input_three_switch, // closes data-out to analog input three
  output logic dataout_to_input_two_switch, // closes data-out to analog input two
  output logic dataout_to_input_one_switch, // closes data-out to analog input one
  output logic dataout_to_cal_zero_switch, // closes data-out to calibration resistor pin zero
  output logic secondary_low_side_switch, // secondary low-side negative switch
  output logic neg_to_tia_short_switch, // shorts negative node to TIA inverting input
  output logic neg_to_cal_one_switch, // negative node to calibration resistor pin one
  output logic neg_direct_sense_switch, // negative node straight to sense electrode pin
  output logic [6:0] neg_individual_switch // individual negative-node switches, bits 6..0
);
  switch_matrix_pkg::bank_s cur_r;
  switch_matrix_pkg::bank_s cur_nxt;
  logic [31:0] driveNode;
  logic [31:0] negNode;
  logic wrDrive;
  logic wrNeg;
  logic wrFire;

  // address decode shared by read and write paths
  function automatic logic [1:0] decode(input logic [15:0] addr);
    decode = 2'h0;
    if (addr == `DRIVE_NODE_SWITCH_CONTROL_ADDR) begin
      decode = 2'h1;
    end else if (addr == `NEGATIVE_NODE_SWITCH_CONTROL_ADDR) begin
      decode = 2'h2;
    end
  endfunction

  // write commits when both address and data are held in idle
  assign wrFire = (cur_r.wrState == switch_matrix_pkg::WR_IDLE) && cur_r.awHeld && cur_r.wHeld;
  assign wrDrive = wrFire && (decode(cur_r.awAddr) == 2'h1);
  assign wrNeg = wrFire && (decode(cur_r.awAddr) == 2'h2);

  switch_bit_register #(
    .RESET_VALUE(`DRIVE_NODE_RESET),
    .WRITE_MASK(`DRIVE_NODE_WMASK)
  ) uDrive (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .wrEn(wrDrive),
    .wrData(cur_r.wData),
    .wrStrb(cur_r.wStrb),
    .value_r(driveNode)
  );

  switch_bit_register #(
    .RESET_VALUE(`NEGATIVE_NODE_RESET),
    .WRITE_MASK(`NEGATIVE_NODE_WMASK)
  ) uNeg (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .wrEn(wrNeg),
    .wrData(cur_r.wData),
    .wrStrb(cur_r.wStrb),
    .value_r(negNode)
  );

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.driveNode = driveNode;
    cur_nxt.negNode = negNode;
    // capture address and data independently, in either order
    if (!cur_r.awHeld && s_axi_awvalid) begin
      cur_nxt.awHeld = 1'b1;
      cur_nxt.awAddr = s_axi_awaddr[15:0];
    end
    if (!cur_r.wHeld && s_axi_wvalid) begin
      cur_nxt.wHeld = 1'b1;
      cur_nxt.wData = s_axi_wdata;
      cur_nxt.wStrb = s_axi_wstrb;
    end
    case (cur_r.wrState)
      switch_matrix_pkg::WR_IDLE: begin
        if (wrFire) begin
          cur_nxt.bResp = (decode(cur_r.awAddr) == 2'h0) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
          cur_nxt.wrState = switch_matrix_pkg::WR_RESP;
        end
      end
      switch_matrix_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          cur_nxt.awHeld = 1'b0;
          cur_nxt.wHeld = 1'b0;
          cur_nxt.wrState = switch_matrix_pkg::WR_IDLE;
        end
      end
      default: begin
        cur_nxt.wrState = switch_matrix_pkg::WR_IDLE;
      end
    endcase
    case (cur_r.rdState)
      switch_matrix_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          case (decode(s_axi_araddr[15:0]))
            2'h1: begin
              cur_nxt.rData = driveNode;
              cur_nxt.rResp = `AXI_RESP_OKAY;
            end
            2'h2: begin
              cur_nxt.rData = negNode;
              cur_nxt.rResp = `AXI_RESP_OKAY;
            end
            default: begin
              cur_nxt.rData = 32'h0000_0000;
              cur_nxt.rResp = `AXI_RESP_SLVERR;
            end
          endcase
          cur_nxt.rdState = switch_matrix_pkg::RD_DATA;
        end
      end
      switch_matrix_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          cur_nxt.rdState = switch_matrix_pkg::RD_IDLE;
        end
      end
      default: begin
        cur_nxt.rdState = switch_matrix_pkg::RD_IDLE;
      end
    endcase
    // ready and valid kept as flops so the bus sees no decode glitch
    cur_nxt.awReady = !cur_nxt.awHeld;
    cur_nxt.wReady = !cur_nxt.wHeld;
    cur_nxt.bValid = cur_nxt.wrState == switch_matrix_pkg::WR_RESP;
    cur_nxt.arReady = cur_nxt.rdState == switch_matrix_pkg::RD_IDLE;
    cur_nxt.rValid = cur_nxt.rdState == switch_matrix_pkg::RD_DATA;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur_r.wrState <= switch_matrix_pkg::WR_IDLE;
      cur_r.rdState <= switch_matrix_pkg::RD_IDLE;
      cur_r.awHeld <= 1'b0;
      cur_r.awAddr <= 16'h0000;
      cur_r.wHeld <= 1'b0;
      cur_r.wData <= 32'h0000_0000;
      cur_r.wStrb <= 4'h0;
      cur_r.bResp <= 2'h0;
      cur_r.rData <= 32'h0000_0000;
      cur_r.rResp <= 2'h0;
      cur_r.awReady <= 1'b1;
      cur_r.wReady <= 1'b1;
      cur_r.bValid <= 1'b0;
      cur_r.arReady <= 1'b1;
      cur_r.rValid <= 1'b0;
      cur_r.driveNode <= `DRIVE_NODE_RESET;
      cur_r.negNode <= `NEGATIVE_NODE_RESET;
    end else if (ce) begin
      cur_r <= cur_nxt;
    end
  end

  // handshake outputs straight from their flops
  assign s_axi_awready = cur_r.awReady;
  assign s_axi_wready = cur_r.wReady;
  assign s_axi_bvalid = cur_r.bValid;
  assign s_axi_bresp = cur_r.bResp;
  assign s_axi_arready = cur_r.arReady;
  assign s_axi_rvalid = cur_r.rValid;
  assign s_axi_rdata = cur_r.rData;
  assign s_axi_rresp = cur_r.rResp;

  // switch enables from the registered copies, one cycle after the register
  assign drive_to_aux_pin_switch = cur_r.driveNode[`DRIVE_TO_AUX_PIN_BIT];
  assign drive_to_sense_pin_switch = cur_r.driveNode[`DRIVE_TO_SENSE_PIN_BIT];
  assign dataout_to_counter_pin_switch = cur_r.driveNode[`DATAOUT_TO_COUNTER_PIN_BIT];
  assign dataout_to_input_three_switch = cur_r.driveNode[`DATAOUT_TO_INPUT_THREE_BIT];
  assign dataout_to_input_two_switch = cur_r.driveNode[`DATAOUT_TO_INPUT_TWO_BIT];
  assign dataout_to_input_one_switch = cur_r.driveNode[`DATAOUT_TO_INPUT_ONE_BIT];
  assign dataout_to_cal_zero_switch = cur_r.driveNode[`DATAOUT_TO_CAL_ZERO_BIT];
  assign secondary_low_side_switch = cur_r.negNode[`SECONDARY_LOW_SIDE_BIT];
  assign neg_to_tia_short_switch = cur_r.negNode[`NEG_TO_TIA_SHORT_BIT];
  assign neg_to_cal_one_switch = cur_r.negNode[`NEG_TO_CAL_ONE_BIT];
  assign neg_direct_sense_switch = cur_r.negNode[`NEG_DIRECT_SENSE_BIT];
  assign neg_individual_switch = cur_r.negNode[`NEG_INDIVIDUAL_MSB:0];
endmodule

// ===== verilog/switch_matrix_regs.svh
/*
  register offsets, field positions and reset values for the switch matrix bit control bank.
  assumes inclusion by bare name from the design, checker and testbench files.
*/
`ifndef SWITCH_MATRIX_REGS_SVH
`define SWITCH_MATRIX_REGS_SVH

`define DRIVE_NODE_SWITCH_CONTROL_ADDR 16'h2150
`define NEGATIVE_NODE_SWITCH_CONTROL_ADDR 16'h2154
`define DRIVE_NODE_RESET 32'h0000_0000
`define NEGATIVE_NODE_RESET 32'h0000_0000
`define DRIVE_NODE_WMASK 32'h0000_00df
`define NEGATIVE_NODE_WMASK 32'h0000_0f7f
`define DRIVE_TO_AUX_PIN_BIT 7
`define DRIVE_TO_SENSE_PIN_BIT 6
`define DATAOUT_TO_COUNTER_PIN_BIT 4
`define DATAOUT_TO_INPUT_THREE_BIT 3
`define DATAOUT_TO_INPUT_TWO_BIT 2
`define DATAOUT_TO_INPUT_ONE_BIT 1
`define DATAOUT_TO_CAL_ZERO_BIT 0
`define SECONDARY_LOW_SIDE_BIT 11
`define NEG_TO_TIA_SHORT_BIT 10
`define NEG_TO_CAL_ONE_BIT 9
`define NEG_DIRECT_SENSE_BIT 8
`define NEG_INDIVIDUAL_MSB 6
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ===== verilog/switch_matrix_pkg.sv
/*
  types shared by the switch matrix bit control files.
  assumes the register header is on the include path.
*/
package switch_matrix_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;

  typedef struct packed {
    wr_state_e wrState;
    rd_state_e rdState;
    logic awHeld;
    logic [15:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [1:0] bResp;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic awReady;
    logic wReady;
    logic bValid;
    logic arReady;
    logic rValid;
    logic [31:0] driveNode;
    logic [31:0] negNode;
  } bank_s;
endpackage

// ===== verilog/switch_bit_register.sv
/*
  one 32-bit switch control register with per-bit write mask and byte strobes.
  assumes write strobe and data arrive on the same clock; masked bits stay zero.
*/
`timescale 1ns/1ns
`include "switch_matrix_regs.svh"

module switch_bit_register #(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
  parameter logic [31:0] WRITE_MASK = 32'hffff_ffff
) (
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic wrEn, // one-cycle write strobe
  input wire logic [31:0] wrData, // write data
  input wire logic [3:0] wrStrb, // byte enables
  output logic [31:0] value_r // stored value
);
  logic [31:0] value_nxt;
  logic [31:0] laneMask;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLane
      assign laneMask[8*g +: 8] = {8{wrStrb[g]}};
    end
  endgenerate

  always_comb begin
    value_nxt = value_r;
    if (wrEn) begin
      value_nxt = ((value_r & ~laneMask) | (wrData & laneMask)) & WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      value_r <= RESET_VALUE;
    end else if (ce) begin
      value_r <= value_nxt;
    end
  end
endmodule

// ===== verif/switch_matrix_bit_control_checker.sv
/* assertions on the switch bank ports.
   assumes a bind onto the top module and a single clock. */
`timescale 1ns/1ns
`include "switch_matrix_regs.svh"
module switch_matrix_bit_control_checker (
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic ce, // enable
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic [1:0] s_axi_bresp, // b
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic [15:0] s_axi_araddr, // ar
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic [31:0] s_axi_rdata, // r
  input wire logic [1:0] s_axi_rresp, // r
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready, // r
  input wire logic drive_to_aux_pin_switch, // switch
  input wire logic dataout_to_cal_zero_switch, // switch
  input wire logic secondary_low_side_switch, // switch
  input wire logic [6:0] neg_individual_switch // switches
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [9:0] sw;
  assign sw = {drive_to_aux_pin_switch, dataout_to_cal_zero_switch, secondary_low_side_switch, neg_individual_switch};
  AST_RESET_OPEN: assert property ($rose(resetn) |-> sw == 10'h000)
    else $error("switch closed after reset");
  AST_WRITE_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce ##1 ce
    |=> s_axi_bvalid) else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_ONE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  AST_RSVD_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h00000)
    else $error("reserved bits read nonzero");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && ce && s_axi_araddr != `DRIVE_NODE_SWITCH_CONTROL_ADDR
    && s_axi_araddr != `NEGATIVE_NODE_SWITCH_CONTROL_ADDR |=> s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  AST_SW_CAUSE: assert property ($changed(sw) |-> $past(s_axi_bvalid) || !$past(resetn))
    else $error("switch moved without a write");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `AXI_RESP_SLVERR);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (neg_individual_switch == 7'h40);
endmodule
bind switch_matrix_bit_control switch_matrix_bit_control_checker i_switch_matrix_bit_control_checker (.*);

// ===== verif/switch_matrix_bit_control_tb.sv
/* self-checking bench for the switch bank over AXI4-Lite.
   assumes the checker file binds itself onto the design. */
`timescale 1ns/1ns
`include "switch_matrix_regs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module switch_matrix_bit_control_tb;
  logic clk = 0, resetn = 0, ce = 1;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic drive_to_aux_pin_switch, drive_to_sense_pin_switch, dataout_to_counter_pin_switch;
  logic dataout_to_input_three_switch, dataout_to_input_two_switch, dataout_to_input_one_switch;
  logic dataout_to_cal_zero_switch, secondary_low_side_switch, neg_to_tia_short_switch;
  logic neg_to_cal_one_switch, neg_direct_sense_switch;
  logic [6:0] neg_individual_switch;
  logic [7:0] drvOut;
  logic [11:0] negOut;
  int fail_count = 0, total_checks = 0, cycles = 0;
  assign drvOut = {drive_to_aux_pin_switch, drive_to_sense_pin_switch, 1'b0, dataout_to_counter_pin_switch,
    dataout_to_input_three_switch, dataout_to_input_two_switch, dataout_to_input_one_switch, dataout_to_cal_zero_switch};
  assign negOut = {secondary_low_side_switch, neg_to_tia_short_switch, neg_to_cal_one_switch,
    neg_direct_sense_switch, 1'b0, neg_individual_switch};
  switch_matrix_bit_control i_switch_matrix_bit_control (.*);
  initial forever #25 clk = ~clk;
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end
  // ready answers one edge after valid, so the hold window is exercised
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    forever begin
      @(posedge clk);
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        break;
      end
      s_axi_bready <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 0;
    end
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    forever begin
      @(posedge clk);
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        break;
      end
      s_axi_rready <= s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 0;
    end
  endtask
  task automatic t_cleared;
    logic [31:0] v;
    logic [1:0] r;
    `CHK("switches", 20'h0, {drvOut, negOut})
    rd(`DRIVE_NODE_SWITCH_CONTROL_ADDR, v, r);
    `CHK("drive reset", `DRIVE_NODE_RESET, v)
    rd(`NEGATIVE_NODE_SWITCH_CONTROL_ADDR, v, r);
    `CHK("neg reset", `NEGATIVE_NODE_RESET, v)
    $display("test cleared done");
  endtask
  task automatic t_bits(input logic [15:0] a, input logic [31:0] m);
    logic [31:0] v;
    logic [31:0] e;
    logic [1:0] r;
    for (int i = 0; i < 32; i++) begin
      e = (32'h1 << i) & m;
      wr(a, 32'h1 << i, 4'hf, r);
      `CHK("write resp", `AXI_RESP_OKAY, r)
      repeat (2) @(posedge clk);
      v = (a == `NEGATIVE_NODE_SWITCH_CONTROL_ADDR) ? {20'h0, negOut} : {24'h0, drvOut};
      `CHK("switch outputs", e, v)
      rd(a, v, r);
      `CHK("readback", e, v)
      `CHK("read resp", `AXI_RESP_OKAY, r)
    end
    $display("test bits %h done", a);
  endtask
  task automatic t_lanes;
    logic [31:0] v;
    logic [1:0] r;
    wr(`NEGATIVE_NODE_SWITCH_CONTROL_ADDR, 32'hffff_ffff, 4'h2, r);
    rd(`NEGATIVE_NODE_SWITCH_CONTROL_ADDR, v, r);
    `CHK("neg lane one", 32'h0000_0f00, v)
    wr(`DRIVE_NODE_SWITCH_CONTROL_ADDR, 32'hffff_ffff, 4'h1, r);
    wr(16'h2158, 32'h0, 4'hf, r);
    `CHK("unmapped bresp", `AXI_RESP_SLVERR, r)
    rd(16'h2158, v, r);
    `CHK("unmapped rresp", `AXI_RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0, v)
    rd(`DRIVE_NODE_SWITCH_CONTROL_ADDR, v, r);
    `CHK("drive lane zero", 32'h0000_00df, v)
    $display("test lanes done");
  endtask
  // write offered while the clock enable is low must wait until it returns
  task automatic t_freeze;
    logic [1:0] r;
    @(posedge clk);
    ce <= 0;
    s_axi_awaddr <= `DRIVE_NODE_SWITCH_CONTROL_ADDR;
    s_axi_wdata <= 32'h0000_0002;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    repeat (3) @(posedge clk);
    `CHK("frozen bvalid", 1'b0, s_axi_bvalid)
    `CHK("frozen switch", 1'b0, dataout_to_input_one_switch)
    ce <= 1;
    @(posedge clk);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1;
    @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    `CHK("thawed bresp", `AXI_RESP_OKAY, r)
    repeat (2) @(posedge clk);
    `CHK("thawed switch", 1'b1, dataout_to_input_one_switch)
    $display("test freeze done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    t_cleared();
    t_bits(`DRIVE_NODE_SWITCH_CONTROL_ADDR, 32'h0000_00df);
    t_bits(`NEGATIVE_NODE_SWITCH_CONTROL_ADDR, 32'h0000_0f7f);
    t_lanes();
    resetn <= 0;
    repeat (2) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    t_cleared();
    t_freeze();
    conclude();
  end
endmodule
